// [detect_filter.sv]
/*
  debounce for one current detection: the flag follows the raw
  comparison only after it has held for the programmed time.
  assumes a millisecond tick on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module detect_filter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ms_tick,
  input  wire logic [13:0] filter_ms,
  input  wire logic        raw,
  output var  logic        flag_r
);

  logic [13:0] held_r;

  // ----------------------------------------------------------------
  // hold counter; zero filter time updates at once
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= 14'h0000;
      flag_r <= 1'b0;
    end else if (raw == flag_r) begin
      held_r <= 14'h0000;
    end else if (filter_ms == 14'h0000) begin
      flag_r <= raw;
    end else if (ms_tick) begin
      if (held_r + 14'h0001 >= filter_ms) begin
        flag_r <= raw;
        held_r <= 14'h0000;
      end else begin
        held_r <= held_r + 14'h0001;
      end
    end
  end

endmodule : detect_filter

`default_nettype wire

// [drive_status_warning_outputs.sv]
/*
  status and warning outputs of a motor drive: major failure latch,
  two overload warnings, low current flag, three terminal selectors
  with active state, registers over apb and a level interrupt.
  assumes current, run and trip inputs come from logic on pclk.
*/
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "drive_warn_defs.svh"

// Functional notes
// - three terminals each driven by selected function
// - code 53 routes major failure flag
// - major failure only for four listed trips
// - major trip stays latched through reset request
// - warning one when current exceeds level one
// - code 03 warning one, 26 warning two
// - overload mode 00 running, 01 constant speed
// - levels programmable 0.00 to 2.00 rated
// - one filter time 0 to 9999 ms
// - code 43 low flag at or below level
// - low mode 00 running, 01 constant speed
// - active state 00 open, 01 inverted closed
module drive_status_warning_outputs
  import drive_warn_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire drive_meas_s meas,
  input  wire logic        trip_valid,
  input  wire logic [7:0]  trip_code,
  input  wire logic        trip_reset_req,
  output var  logic [2:0]  terminal_out,
  output var  logic        irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // major failure class of a trip code
  function automatic logic is_major(input logic [7:0] code);
    is_major = (code == `TRIP_MEMORY) || (code == `TRIP_PROCESSOR) ||
               (code == `TRIP_GROUND) || (code == `TRIP_POWER_DRV);
  endfunction : is_major

  // clamp a level to the 2.00 times rated ceiling
  function automatic logic [8:0] clamp_level(input logic [31:0] v);
    clamp_level = (v[15:0] > {7'h00, `LEVEL_MAX}) ? `LEVEL_MAX : v[8:0];
  endfunction : clamp_level

  // signal named by a function code
  // unknown codes read as inactive
  function automatic logic pick(input logic [7:0] fn,
                                input warn_flags_s f,
                                input logic alarm);
    case (fn)
      `FN_OVERLOAD_ONE: pick = f.warn_one;
      `FN_OVERLOAD_TWO: pick = f.warn_two;
      `FN_LOW_CURRENT:  pick = f.low;
      `FN_MAJOR:        pick = f.major;
      `FN_ALARM:        pick = alarm;
      default:          pick = 1'b0;
    endcase
  endfunction : pick

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [23:0] term_sel_r;     // terminal_a, terminal_b, relay selects
  logic [2:0]  term_act_r;     // active states, bit per terminal
  logic        ovl_mode_r;     // overload_mode_select
  logic        low_mode_r;     // low_current_mode_select
  logic [8:0]  level_one_r;
  logic [8:0]  level_two_r;
  logic [8:0]  low_level_r;
  logic [13:0] filter_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_en_r;
  logic [7:0]  trip_r;
  logic        trip_major_r;
  logic [16:0] tick_cnt_r;
  logic        ms_tick_r;
  warn_flags_s flags;
  warn_flags_s flags_d_r;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        eval_ovl;
  logic        eval_low;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // access phase strobes; the slave never inserts wait states
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;

  // address decode for mapped words
  always_comb begin
    case (paddr)
      `OFF_TERM_SEL, `OFF_TERM_ACT, `OFF_MODE, `OFF_LEVEL_ONE,
      `OFF_LEVEL_TWO, `OFF_LOW_LEVEL, `OFF_FILTER, `OFF_STATUS,
      `OFF_IRQ_STAT, `OFF_IRQ_EN, `OFF_IRQ_CLR, `OFF_TRIP:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // unmapped words are refused in the access phase only
  assign pslverr = (wr_en || rd_en) && !addr_ok;

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // software settings; levels and filter clamp to their ceilings
  // on pwdata[15:0] only, so a write with higher bits set is truncated, not clamped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_sel_r  <= `RST_TERM_SEL;
      term_act_r  <= `RST_TERM_ACT;
      ovl_mode_r  <= 1'b0;
      low_mode_r  <= 1'b0;
      level_one_r <= 9'h000;
      level_two_r <= 9'h000;
      low_level_r <= 9'h000;
      filter_r    <= 14'h0000;
      irq_en_r    <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        `OFF_TERM_SEL:  term_sel_r  <= pwdata[23:0];
        `OFF_TERM_ACT:  term_act_r  <= pwdata[2:0];
        `OFF_MODE: begin
          ovl_mode_r <= pwdata[0];
          low_mode_r <= pwdata[1];
        end
        `OFF_LEVEL_ONE: level_one_r <= clamp_level(pwdata);
        `OFF_LEVEL_TWO: level_two_r <= clamp_level(pwdata);
        `OFF_LOW_LEVEL: low_level_r <= clamp_level(pwdata);
        `OFF_FILTER: begin
          filter_r <= (pwdata[15:0] > {2'b00, `FILTER_MAX}) ?
                      `FILTER_MAX : pwdata[13:0];
        end
        `OFF_IRQ_EN:    irq_en_r    <= pwdata[3:0];
        // read-only and unmapped words ignore writes
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // loaded in the setup cycle so it stands through the access
  // phase; the clear register and unmapped words read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_TERM_SEL:  prdata <= {8'h00, term_sel_r};
        `OFF_TERM_ACT:  prdata <= {29'h0, term_act_r};
        `OFF_MODE:      prdata <= {30'h0, low_mode_r, ovl_mode_r};
        `OFF_LEVEL_ONE: prdata <= {23'h0, level_one_r};
        `OFF_LEVEL_TWO: prdata <= {23'h0, level_two_r};
        `OFF_LOW_LEVEL: prdata <= {23'h0, low_level_r};
        `OFF_FILTER:    prdata <= {18'h0, filter_r};
        `OFF_STATUS:    prdata <= {25'h0, terminal_out, flags};
        `OFF_IRQ_STAT:  prdata <= {28'h0, irq_stat_r};
        `OFF_IRQ_EN:    prdata <= {28'h0, irq_en_r};
        `OFF_TRIP:      prdata <= {23'h0, trip_major_r, trip_r};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trip latch
  // ----------------------------------------------------------------
  // a new trip is held; reset requests release only ordinary trips
  // a latched major trip also blocks newer codes, so its cause
  // stays readable until presetn; ordinary trips are replaced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_r       <= `TRIP_NONE;
      trip_major_r <= 1'b0;
    end else if (trip_valid && !trip_major_r) begin
      trip_r       <= trip_code;
      trip_major_r <= is_major(trip_code);
    end else if (trip_reset_req && !trip_major_r) begin
      trip_r       <= `TRIP_NONE;
    end
  end

  assign flags.major = trip_major_r;

  // ----------------------------------------------------------------
  // millisecond tick for the filter
  // ----------------------------------------------------------------
  // free running divider, so a filter time of n ms waits between
  // n-1 and n ms after the comparison settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 17'h00000;
      ms_tick_r  <= 1'b0;
    end else if (tick_cnt_r == 17'(`TICKS_PER_MS - 1)) begin
      tick_cnt_r <= 17'h00000;
      ms_tick_r  <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
      ms_tick_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // current detections
  // ----------------------------------------------------------------
  // constant speed is running with no ramp in progress;
  // mode 01 restricts a detection to constant speed
  assign eval_ovl = meas.running &&
                    (!ovl_mode_r || meas.at_speed);
  assign eval_low = meas.running &&
                    (!low_mode_r || meas.at_speed);

  // both overload comparators share the overload mode gate
  detect_filter u_filt_one (
    .pclk      (pclk),
    .presetn   (presetn),
    .ms_tick   (ms_tick_r),
    .filter_ms (filter_r),
    .raw       (eval_ovl && (meas.current > level_one_r)),
    .flag_r    (flags.warn_one)
  );

  // second warning compares against its own threshold
  detect_filter u_filt_two (
    .pclk      (pclk),
    .presetn   (presetn),
    .ms_tick   (ms_tick_r),
    .filter_ms (filter_r),
    .raw       (eval_ovl && (meas.current > level_two_r)),
    .flag_r    (flags.warn_two)
  );

  // low current detection includes the level itself
  detect_filter u_filt_low (
    .pclk      (pclk),
    .presetn   (presetn),
    .ms_tick   (ms_tick_r),
    .filter_ms (filter_r),
    .raw       (eval_low && (meas.current <= low_level_r)),
    .flag_r    (flags.low)
  );

  // ----------------------------------------------------------------
  // terminal outputs
  // ----------------------------------------------------------------
  // each terminal picks its signal, then its active state inverts
  // it; an unknown code gives the inactive contact level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_out <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        terminal_out[i] <= pick(term_sel_r[i*8 +: 8], flags,
                                trip_r != `TRIP_NONE)
                           ^ term_act_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: rising flags set sticky bits, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_d_r  <= '0;
      irq_stat_r <= 4'h0;
    end else begin
      flags_d_r  <= flags;
      irq_stat_r <= (irq_stat_r &
                     ~((wr_en && paddr == `OFF_IRQ_CLR) ?
                       pwdata[3:0] : 4'h0)) |
                    (flags & ~flags_d_r);
    end
  end

  // a clear in the cycle of a new rising edge loses, so no event
  // is dropped; the level follows any enabled standing bit
  assign irq = |(irq_stat_r & irq_en_r);

endmodule : drive_status_warning_outputs

`default_nettype wire

// [drive_warn_defs.svh]
/*
  offsets, function and trip codes, reset values and timing counts for the
  drive status warning block.
  assumes a 125 MHz pclk and an apb register bus with 32-bit data.
*/
`ifndef DRIVE_WARN_DEFS_SVH
`define DRIVE_WARN_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_TERM_SEL     12'h000
`define OFF_TERM_ACT     12'h004
`define OFF_MODE         12'h008
`define OFF_LEVEL_ONE    12'h00c
`define OFF_LEVEL_TWO    12'h010
`define OFF_LOW_LEVEL    12'h014
`define OFF_FILTER       12'h018
`define OFF_STATUS       12'h01c
`define OFF_IRQ_STAT     12'h020
`define OFF_IRQ_EN       12'h024
`define OFF_IRQ_CLR      12'h028
`define OFF_TRIP         12'h02c

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define FN_OVERLOAD_ONE  8'h03
`define FN_ALARM         8'h05
`define FN_OVERLOAD_TWO  8'h1a
`define FN_LOW_CURRENT   8'h2b
`define FN_MAJOR         8'h35

// ----------------------------------------------------------------
// trip codes and reset values
// ----------------------------------------------------------------
`define TRIP_NONE        8'h00
`define TRIP_MEMORY      8'h08
`define TRIP_PROCESSOR   8'h0b
`define TRIP_GROUND      8'h0e
`define TRIP_POWER_DRV   8'h1e
`define RST_TERM_SEL     24'h050000
`define RST_TERM_ACT     3'h4
`define LEVEL_MAX        9'h0c8
`define FILTER_MAX       14'h270f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ          125
`define FILTER_UNIT_US   1000
`define TICKS_PER_MS     (`CLK_MHZ * `FILTER_UNIT_US)

`endif

// [drive_warn_pkg.sv]
/*
  types shared by the drive status warning block.
  assumes the defs header is compiled alongside.
*/
`default_nettype none

package drive_warn_pkg;

  // one current detection comparator input
  typedef struct packed {
    logic [8:0] current;   // output current, hundredths of rated
    logic       running;
    logic       at_speed;  // output frequency equals command
  } drive_meas_s;

  // the four warning flags
  typedef struct packed {
    logic major;
    logic low;
    logic warn_two;
    logic warn_one;
  } warn_flags_s;

endpackage : drive_warn_pkg

`default_nettype wire

// [tb_top.sv]
/* self-checking bench for the drive status warning block.
   assumes the defs header, the package and the term_watch model. */
`timescale 1ns/100ps
`default_nettype none
`include "drive_warn_defs.svh"

module tb_top
  import drive_warn_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  drive_meas_s meas;
  logic        trip_valid;
  logic [7:0]  trip_code;
  logic        trip_reset_req;
  logic [2:0]  terminal_out;
  logic        irq;
  logic [2:0]  contact;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          checks;

  drive_status_warning_outputs u_drive_status_warning_outputs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .meas, .trip_valid, .trip_code, .trip_reset_req,
    .terminal_out, .irq);
  term_watch u_term_watch (.pclk, .presetn, .terminal_out, .contact);

  // free running bus clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      num_errors++;
    if (got !== exp)
      $display("[ERR] %0t got %h want %h", $time, got, exp);
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // set mode and current, then judge the contacts the system sees
  task automatic step(input logic [1:0] m, input logic [8:0] c,
                      input logic r, input logic s, input logic [2:0] e);
    wr(`OFF_MODE, {30'h0, m});
    meas <= '{c, r, s};
    repeat (4) @(posedge pclk);
    chk(32'(contact), 32'(e));
  endtask : step

  task automatic irqc(input logic e);
    @(posedge pclk);
    chk(32'(irq), 32'(e));
  endtask : irqc

  task automatic t_defaults();
    repeat (4) @(posedge pclk);
    chk(32'(contact), 32'h4);
    rdc(`OFF_TERM_SEL, 32'h050000);
    rdc(`OFF_TERM_ACT, 32'h4);
    rdc(`OFF_IRQ_CLR, 32'h0);
    rdc(12'h030, 32'h0);
    chk(32'(err), 32'h1);
    wr(`OFF_LOW_LEVEL, 32'h1ff);
    rdc(`OFF_LOW_LEVEL, 32'h0c8);
    wr(`OFF_FILTER, 32'h3fff);
    rdc(`OFF_FILTER, 32'h270f);
    $display("defaults finished");
  endtask : t_defaults

  task automatic t_levels();
    wr(`OFF_TERM_SEL, 32'h2b1a03);
    wr(`OFF_TERM_ACT, 32'h0);
    wr(`OFF_LEVEL_ONE, 32'h64);
    wr(`OFF_LEVEL_TWO, 32'h96);
    wr(`OFF_LOW_LEVEL, 32'h32);
    wr(`OFF_FILTER, 32'h0);
    step(2'h0, 9'h078, 1'b1, 1'b0, 3'h1);
    step(2'h0, 9'h0a0, 1'b1, 1'b0, 3'h3);
    rdc(`OFF_STATUS, 32'h33);
    step(2'h0, 9'h096, 1'b1, 1'b0, 3'h1);
    step(2'h0, 9'h064, 1'b1, 1'b0, 3'h0);
    step(2'h0, 9'h032, 1'b1, 1'b0, 3'h4);
    step(2'h0, 9'h032, 1'b0, 1'b0, 3'h0);
    step(2'h3, 9'h0a0, 1'b1, 1'b0, 3'h0);
    step(2'h3, 9'h0a0, 1'b1, 1'b1, 3'h3);
    step(2'h3, 9'h032, 1'b1, 1'b0, 3'h0);
    step(2'h1, 9'h032, 1'b1, 1'b0, 3'h4);
    wr(`OFF_TERM_ACT, 32'h7);
    step(2'h0, 9'h078, 1'b1, 1'b0, 3'h6);
    wr(`OFF_TERM_ACT, 32'h0);
    wr(`OFF_FILTER, 32'h1);
    step(2'h0, 9'h0a0, 1'b1, 1'b0, 3'h1);
    wr(`OFF_FILTER, 32'h0);
    step(2'h0, 9'h0a0, 1'b1, 1'b0, 3'h3);
    $display("levels finished");
  endtask : t_levels

  task automatic t_irq();
    wr(`OFF_LEVEL_ONE, 32'hc8);
    step(2'h0, 9'h078, 1'b1, 1'b0, 3'h0);
    wr(`OFF_LEVEL_ONE, 32'h64);
    step(2'h0, 9'h078, 1'b1, 1'b0, 3'h1);
    step(2'h0, 9'h064, 1'b1, 1'b0, 3'h0);
    wr(`OFF_IRQ_CLR, 32'hf);
    wr(`OFF_IRQ_EN, 32'h1);
    step(2'h0, 9'h078, 1'b1, 1'b0, 3'h1);
    irqc(1'b1);
    rdc(`OFF_IRQ_STAT, 32'h1);
    wr(`OFF_IRQ_EN, 32'h0);
    irqc(1'b0);
    wr(`OFF_IRQ_EN, 32'h1);
    irqc(1'b1);
    wr(`OFF_IRQ_CLR, 32'h1);
    irqc(1'b0);
    rdc(`OFF_IRQ_STAT, 32'h0);
    $display("interrupt finished");
  endtask : t_irq

  task automatic t_major();
    logic [7:0] code [5];
    logic       maj;
    code = '{8'h05, `TRIP_MEMORY, `TRIP_PROCESSOR, `TRIP_GROUND,
             `TRIP_POWER_DRV};
    meas <= '0;
    for (int i = 0; i < 5; i++) begin
      maj = (i != 0);
      do_reset();
      wr(`OFF_TERM_SEL, 32'h050535);
      trip_valid <= 1'b1;
      trip_code  <= code[i];
      @(posedge pclk);
      trip_valid <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(contact), {29'h0, 2'b01, maj});
      rdc(`OFF_TRIP, {23'h0, maj, code[i]});
      trip_reset_req <= 1'b1;
      @(posedge pclk);
      trip_reset_req <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(contact), maj ? 32'h3 : 32'h4);
      rdc(`OFF_TRIP, maj ? {23'h0, 1'b1, code[i]} : 32'h0);
    end
    $display("major finished");
  endtask : t_major

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    num_errors = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    meas = '0;
    trip_valid = 1'b0;
    trip_code = 8'h0;
    trip_reset_req = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_levels();
    t_irq();
    t_major();
    stop_test();
  end

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
endmodule : tb_top

bind drive_status_warning_outputs warn_checker u_warn_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .trip_valid, .trip_code);
`default_nettype wire

// [term_watch.sv]
/* system side model: samples the three output contacts once a clock.
   assumes terminal_out comes from the warning block on pclk. */
`timescale 1ns/100ps
`default_nettype none

module term_watch (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] terminal_out,
  output var  logic [2:0] contact
);
  // contacts read open while the system is held in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      contact <= 3'h0;
    else
      contact <= terminal_out;
  end
endmodule : term_watch
`default_nettype wire

// [warn_checker_asserts.sv]
/* assertions on the apb port and the major trip latch of the
   drive status warning block.
   assumes it is bound onto drive_status_warning_outputs. */
`timescale 1ns/100ps
`default_nettype none
`include "drive_warn_defs.svh"

module warn_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        trip_valid,
  input wire logic [7:0]  trip_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  logic rd;
  logic unmap;
  logic maj_r;

  // access phase decode
  assign acc   = psel && penable;
  assign rd    = acc && !pwrite;
  assign unmap = paddr > `OFF_TRIP;

  // mirror of the major trip latch, only presetn clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      maj_r <= 1'b0;
    else if (trip_valid && (trip_code == `TRIP_MEMORY ||
             trip_code == `TRIP_PROCESSOR || trip_code == `TRIP_GROUND ||
             trip_code == `TRIP_POWER_DRV))
      maj_r <= 1'b1;
  end

  ready_high_a: assert property (pready)
    else $error("pready dropped");
  unmapped_err_a: assert property (acc && unmap |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && !unmap && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  setup_quiet_a: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  unmapped_zero_a: assert property (rd && unmap |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  clr_zero_a: assert property (rd && paddr == `OFF_IRQ_CLR
    |-> prdata == 32'h0) else $error("clear register read not zero");
  major_hold_a: assert property (
    rd && paddr == `OFF_TRIP && $past(maj_r, 2) |-> prdata[8])
    else $error("major trip released");
  major_only_a: assert property (
    rd && paddr == `OFF_TRIP && !maj_r |-> !prdata[8])
    else $error("major set by other trip");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved");
endmodule : warn_checker
`default_nettype wire
